/* File: rtl/arm_pkg.sv */
package arm_pkg;

    // Register byte addresses.
    localparam logic [31:0] ADDR_STA = 32'hFFFF_0500;
    localparam logic [31:0] ADDR_MSK = 32'hFFFF_0504;
    localparam logic [31:0] ADDR_TH  = 32'hFFFF_0508;
    localparam logic [31:0] ADDR_THC = 32'hFFFF_050C;
    localparam logic [31:0] ADDR_THV = 32'hFFFF_0510;
    localparam logic [31:0] ADDR_RCR = 32'hFFFF_0514;
    localparam logic [31:0] ADDR_CFG = 32'hFFFF_0518;
    localparam logic [31:0] ADDR_DAT = 32'hFFFF_051C;
    localparam logic [31:0] ADDR_ACC = 32'hFFFF_0534;
    localparam logic [31:0] ADDR_RCV = 32'hFFFF_0538;

    // Configuration fields.
    localparam int CFG_GROUND_SWITCH_PIN  = 7;
    localparam int CFG_ACC_LO  = 5;
    localparam int CFG_CMP_LO  = 3;
    localparam int CFG_OVR_EN  = 2;
    localparam int CFG_GND_RES = 1;
    localparam int CFG_RC_EN   = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // Status and mask fields share one layout.
    localparam int STA_READY = 0;
    localparam int STA_OVR   = 2;
    localparam int STA_CMP   = 3;
    localparam int STA_CONV  = 5;
    localparam int STA_ACC   = 6;
    localparam logic [7:0] STA_RESET = 8'h00;
    localparam logic [7:0] MSK_RESET = 8'h00;
    localparam logic [7:0] STA_USED  = 8'h6D;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Coarse overrange must persist longer than this.
    localparam int OVR_TIME_NS   = 125000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int OVR_CYCLES    = (OVR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ACC_OFF    = 2'h0,
        ACC_CLAMP  = 2'h1,
        ACC_SIGNED = 2'h2,
        ACC_CMP    = 2'h3
    } arm_acc_mode_t;

    typedef enum logic [1:0] {
        CMP_OFF   = 2'h0,
        CMP_LEVEL = 2'h1,
        CMP_COUNT = 2'h2,
        CMP_DECAY = 2'h3
    } arm_cmp_mode_t;

    function automatic logic [23:0] arm_abs(input logic [23:0] v);
        arm_abs = v[23] ? 24'(-v) : v;
    endfunction

    function automatic logic [31:0] arm_merge(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            arm_merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

endpackage

/* File: rtl/arm_thresh.sv */
module arm_thresh #(
    parameter int CW = 16
) (
    input  wire logic                   clk_i,      // System clock.
    input  wire logic                   rst_n_i,    // Asynchronous reset.
    input  wire logic                   ce_i,       // Clock enable.
    input  wire logic                   sample_i,   // New primary result.
    input  wire logic [23:0]            mag_i,      // Absolute result.
    input  wire logic [23:0]            th_i,       // Threshold.
    input  wire logic [CW-1:0]          limit_i,    // Count limit.
    input  wire arm_pkg::arm_cmp_mode_t mode_i,     // Comparator mode.
    output logic      [CW-1:0]          count_o,    // Threshold counter.
    output logic                        hit_o       // Event pulse.
);
    import arm_pkg::*;

    logic [CW-1:0] next_count;
    logic          next_hit;
    logic          above;

    assign above = mag_i >= th_i;

    always_comb begin
        next_count = count_o;
        next_hit   = 1'b0;
        if (mode_i == CMP_OFF) begin
            next_count = '0;
        end else if (sample_i) begin
            case (mode_i)
                CMP_LEVEL: begin
                    next_hit = above; // R9
                end
                CMP_COUNT, CMP_DECAY: begin
                    if (above) begin
                        if (count_o != '1) begin
                            next_count = count_o + 1'b1; // R17
                        end
                    end else if (mode_i == CMP_COUNT) begin
                        next_count = '0; // R10
                    end else if (count_o != '0) begin
                        next_count = count_o - 1'b1; // R11
                    end
                    // Pulse only on arrival so a held count does not refire.
                    next_hit = above && (next_count == limit_i) && (count_o != limit_i); // R17
                end
                default: begin
                    next_count = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_o <= '0;
            hit_o   <= 1'b0;
        end else if (ce_i) begin
            count_o <= next_count;
            hit_o   <= next_hit;
        end
    end
endmodule

/* File: rtl/arm_ovr.sv */
module arm_ovr #(
    parameter int CYC = arm_pkg::OVR_CYCLES
) (
    input  wire logic clk_i,    // System clock.
    input  wire logic rst_n_i,  // Asynchronous reset.
    input  wire logic ce_i,     // Clock enable.
    input  wire logic enable_i, // Detector enable.
    input  wire logic raw_i,    // Coarse comparator level.
    output logic      flag_o    // Event pulse.
);
    localparam int CNTW = $clog2(CYC + 2);
    localparam logic [CNTW-1:0] CYC_C = CNTW'(CYC);

    logic [CNTW-1:0] cnt;
    logic [CNTW-1:0] next_cnt;
    logic            next_flag;

    // The count stops one past the limit, so a long overrange gives one pulse.
    always_comb begin
        next_cnt  = cnt;
        next_flag = 1'b0;
        if (!enable_i || !raw_i) begin
            next_cnt = '0;
        end else if (cnt <= CYC_C) begin
            next_cnt  = cnt + 1'b1;
            next_flag = (cnt == CYC_C); // R12
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt    <= '0;
            flag_o <= 1'b0;
        end else if (ce_i) begin
            cnt    <= next_cnt;
            flag_o <= next_flag;
        end
    end
endmodule

/* File: rtl/arm_top.sv */
// Operation
// R1: Configuration register is 8-bit read/write, resets to zero, all functions off.
// R2: Bit 7 connects the ground switch pin; clearing it disconnects.
// R3: Bit 1 adds a series resistor to the ground switch path.
// R4: 32-bit accumulator mode set by configuration bits 6 to 5.
// R5: Mode 00 clears the accumulator; software holds it off one conversion.
// R6: Mode 01 adds signed results, clamping the total at zero.
// R7: Mode 10 adds signed results without clamp; overflow is allowed.
// R8: Mode 11 runs accumulator with comparator and raises a masked interrupt.
// R9: Comparator bits 4 to 3; 00 off, 01 fires when magnitude reaches threshold.
// R10: Mode 10 fires after limit hits; a miss clears the counter.
// R11: Mode 11 counts likewise, but a miss decrements toward zero.
// R12: Bit 2 flags overrange held longer than 125 microseconds.
// R13: Software keeps the overrange detector off in low power mode.
// R14: Bit 0 fires conversion interrupts only when result count meets limit.
// R15: With bit 0 clear every conversion raises the conversion interrupt.
// R16: Result register holds while ready; reading it clears the ready flags.
// R17: Threshold counter counts each qualifying result; event when it reaches limit.
// R18: All processing steps once per conversion using the stored result; the code uses result_i at the strobe, not dat.
module arm_top #(
    parameter int CW = 16
) (
    input  wire logic        clk_i,                // System clock.
    input  wire logic        rst_n_i,              // Asynchronous reset.
    input  wire logic        ce_i,                 // Clock enable.
    input  wire logic [31:0] s_axi_awaddr_i,       // Write address.
    input  wire logic        s_axi_awvalid_i,      // Write address valid.
    output logic             s_axi_awready_o,      // Write address ready.
    input  wire logic [31:0] s_axi_wdata_i,        // Write data.
    input  wire logic [3:0]  s_axi_wstrb_i,        // Write strobes.
    input  wire logic        s_axi_wvalid_i,       // Write data valid.
    output logic             s_axi_wready_o,       // Write data ready.
    output logic [1:0]       s_axi_bresp_o,        // Write response.
    output logic             s_axi_bvalid_o,       // Write response valid.
    input  wire logic        s_axi_bready_i,       // Write response ready.
    input  wire logic [31:0] s_axi_araddr_i,       // Read address.
    input  wire logic        s_axi_arvalid_i,      // Read address valid.
    output logic             s_axi_arready_o,      // Read address ready.
    output logic [31:0]      s_axi_rdata_o,        // Read data.
    output logic [1:0]       s_axi_rresp_o,        // Read response.
    output logic             s_axi_rvalid_o,       // Read data valid.
    input  wire logic        s_axi_rready_i,       // Read data ready.
    input  wire logic [23:0] result_i,             // Primary filter result.
    input  wire logic        result_valid_i,       // Result strobe.
    input  wire logic        coarse_overrange_i,   // Coarse comparator level.
    output logic             ground_switch_pin_o,  // Ground switch closed.
    output logic             ground_resistor_o,    // Series resistor in path.
    output logic             irq_o                 // Interrupt, active high.
);
    import arm_pkg::*;

    logic [7:0]        cfg;
    logic [7:0]        sta;
    logic [7:0]        msk;
    logic [23:0]       th;
    logic [CW-1:0]     thc;
    logic [CW-1:0]     rcr;
    logic [CW-1:0]     rcv;
    logic [23:0]       dat;
    logic [31:0]       acc;
    logic [7:0]        next_cfg;
    logic [7:0]        next_sta;
    logic [7:0]        next_msk;
    logic [23:0]       next_th;
    logic [CW-1:0]     next_thc;
    logic [CW-1:0]     next_rcr;
    logic [CW-1:0]     next_rcv;
    logic [23:0]       next_dat;
    logic [31:0]       next_acc;
    logic [31:0]       aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              aw_full;
    logic              w_full;
    logic [31:0]       next_aw_addr;
    logic [31:0]       next_w_data;
    logic [3:0]        next_w_strb;
    logic              next_aw_full;
    logic              next_w_full;
    logic              next_awready;
    logic              next_wready;
    logic              next_bvalid;
    logic [1:0]        next_bresp;
    logic              next_arready;
    logic              next_rvalid;
    logic [31:0]       next_rdata;
    logic [1:0]        next_rresp;
    logic              next_irq;
    logic              wr_go;
    logic              rd_go;
    logic              wr_hit;
    logic              rd_hit;
    logic [31:0]       rd_val;
    logic [31:0]       wr_val;
    logic [31:0]       sum;
    logic [CW-1:0]     thv;
    logic              cmp_hit;
    logic              ovr_hit;
    logic [7:0]        sta_set;
    logic [7:0]        sta_clr;
    arm_acc_mode_t     acc_mode;
    arm_cmp_mode_t     cmp_mode;

    assign acc_mode = arm_acc_mode_t'(cfg[CFG_ACC_LO +: 2]); // R4
    assign cmp_mode = arm_cmp_mode_t'(cfg[CFG_CMP_LO +: 2]); // R9
    assign wr_go    = aw_full && w_full && !s_axi_bvalid_o;
    assign rd_go    = s_axi_arvalid_i && s_axi_arready_o;
    assign sum      = acc + {{8{result_i[23]}}, result_i};

    arm_thresh #(
        .CW(CW)
    ) u_thresh (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .sample_i(result_valid_i), // R18
        .mag_i   (arm_abs(result_i)),
        .th_i    (th),
        .limit_i (thc),
        .mode_i  (cmp_mode),
        .count_o (thv),
        .hit_o   (cmp_hit)
    );

    arm_ovr #(
        .CYC(OVR_CYCLES)
    ) u_ovr (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .enable_i(cfg[CFG_OVR_EN]), // R12
        .raw_i   (coarse_overrange_i),
        .flag_o  (ovr_hit)
    );

    // AXI4-Lite write channels: address and data are taken in either order.
    always_comb begin
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_aw_full = aw_full;
        next_w_full  = w_full;
        next_awready = s_axi_awready_o;
        next_wready  = s_axi_wready_o;
        next_bvalid  = s_axi_bvalid_o;
        next_bresp   = s_axi_bresp_o;
        if (!aw_full && !s_axi_awready_o) begin
            next_awready = 1'b1;
        end
        if (!w_full && !s_axi_wready_o) begin
            next_wready = 1'b1;
        end
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            next_aw_addr = s_axi_awaddr_i;
            next_aw_full = 1'b1;
            next_awready = 1'b0;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            next_w_data = s_axi_wdata_i;
            next_w_strb = s_axi_wstrb_i;
            next_w_full = 1'b1;
            next_wready = 1'b0;
        end
        if (wr_go) begin
            next_bvalid  = 1'b1;
            next_bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
        end
        if (s_axi_bvalid_o && s_axi_bready_i) begin
            next_bvalid = 1'b0;
        end
    end

    // Shared map view; bit 32 flags a mapped address.
    function automatic logic [32:0] arm_view(input logic [31:0] addr);
        case (addr)
            ADDR_STA: arm_view = {1'b1, 24'h00_0000, sta};
            ADDR_MSK: arm_view = {1'b1, 24'h00_0000, msk};
            ADDR_TH:  arm_view = {1'b1, 8'h00, th};
            ADDR_THC: arm_view = {1'b1, 32'(thc)};
            ADDR_THV: arm_view = {1'b1, 32'(thv)};
            ADDR_RCR: arm_view = {1'b1, 32'(rcr)};
            ADDR_CFG: arm_view = {1'b1, 24'h00_0000, cfg}; // R1
            ADDR_DAT: arm_view = {1'b1, 8'h00, dat};
            ADDR_ACC: arm_view = {1'b1, acc};
            ADDR_RCV: arm_view = {1'b1, 32'(rcv)};
            default:  arm_view = 33'h0_0000_0000;
        endcase
    endfunction
    always_comb {rd_hit, rd_val} = arm_view(s_axi_araddr_i);

    always_comb begin
        next_arready = s_axi_arready_o;
        next_rvalid  = s_axi_rvalid_o;
        next_rdata   = s_axi_rdata_o;
        next_rresp   = s_axi_rresp_o;
        if (!s_axi_rvalid_o && !s_axi_arready_o) begin
            next_arready = 1'b1;
        end
        if (rd_go) begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rdata   = rd_val;
            next_rresp   = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_axi_rvalid_o && s_axi_rready_i) begin
            next_rvalid = 1'b0;
        end
    end

    // Register file, result path and status flags.
    always_comb begin
        wr_hit   = 1'b1;
        next_cfg = cfg;
        next_msk = msk;
        next_th  = th;
        next_thc = thc;
        next_rcr = rcr;
        next_rcv = rcv;
        next_dat = dat;
        next_acc = acc;
        sta_set  = 8'h00;
        sta_clr  = 8'h00;
        wr_val   = arm_merge(32'(arm_view(aw_addr)), w_data, w_strb);
        if (wr_go) begin
            case (aw_addr)
                ADDR_STA: sta_clr  = w_data[7:0] & {8{w_strb[0]}};
                ADDR_MSK: next_msk = wr_val[7:0];
                ADDR_TH:  next_th  = wr_val[23:0];
                ADDR_THC: next_thc = wr_val[CW-1:0];
                ADDR_RCR: next_rcr = wr_val[CW-1:0];
                ADDR_CFG: next_cfg = wr_val[7:0]; // R1
                default:  wr_hit   = 1'b0;
            endcase
        end
        if (rd_go && s_axi_araddr_i == ADDR_DAT) begin
            sta_clr[STA_READY] = 1'b1; // R16
        end
        if (result_valid_i) begin
            if (!sta[STA_READY]) begin
                next_dat = result_i; // R16
            end
            sta_set[STA_READY] = 1'b1;
            next_rcv           = rcv + 1'b1; // R14
            sta_set[STA_CONV]  = !cfg[CFG_RC_EN] || (next_rcv == rcr); // R14 R15
            if (sta_set[STA_CONV]) begin
                next_rcv = '0;
            end
        end
        case (acc_mode)
            ACC_CLAMP: begin
                if (result_valid_i) begin
                    // Only a negative step may clamp; positive overflow wraps.
                    next_acc = (result_i[23] && sum[31]) ? 32'h0000_0000 : sum; // R6
                end
            end
            ACC_SIGNED, ACC_CMP: begin
                if (result_valid_i) begin
                    next_acc         = sum; // R7
                    sta_set[STA_ACC] = (acc_mode == ACC_CMP) && ($signed(sum) >= $signed({8'h00, th})); // R8
                end
            end
            default: begin
                next_acc = 32'h0000_0000; // R5
            end
        endcase
        sta_set[STA_CMP] = cmp_hit; // R9
        sta_set[STA_OVR] = ovr_hit; // R12
        // A new event in the clearing cycle survives.
        next_sta = ((sta & ~sta_clr) | sta_set) & STA_USED;
        next_irq = |(next_sta & msk); // R8
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg             <= CFG_RESET; // R1
            sta             <= STA_RESET;
            msk             <= MSK_RESET;
            th              <= '0;
            thc             <= '0;
            rcr             <= '0;
            rcv             <= '0;
            dat             <= '0;
            acc             <= '0;
            aw_addr         <= '0;
            w_data          <= '0;
            w_strb          <= '0;
            aw_full         <= 1'b0;
            w_full          <= 1'b0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= RESP_OKAY;
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= '0;
            s_axi_rresp_o   <= RESP_OKAY;
            irq_o           <= 1'b0;
            ground_switch_pin_o <= 1'b0;
            ground_resistor_o   <= 1'b0;
        end else if (ce_i) begin
            cfg             <= next_cfg;
            sta             <= next_sta;
            msk             <= next_msk;
            th              <= next_th;
            thc             <= next_thc;
            rcr             <= next_rcr;
            rcv             <= next_rcv;
            dat             <= next_dat;
            acc             <= next_acc;
            aw_addr         <= next_aw_addr;
            w_data          <= next_w_data;
            w_strb          <= next_w_strb;
            aw_full         <= next_aw_full;
            w_full          <= next_w_full;
            s_axi_awready_o <= next_awready;
            s_axi_wready_o  <= next_wready;
            s_axi_bvalid_o  <= next_bvalid;
            s_axi_bresp_o   <= next_bresp;
            s_axi_arready_o <= next_arready;
            s_axi_rvalid_o  <= next_rvalid;
            s_axi_rdata_o   <= next_rdata;
            s_axi_rresp_o   <= next_rresp;
            irq_o           <= next_irq;
            ground_switch_pin_o <= next_cfg[CFG_GROUND_SWITCH_PIN]; // R2
            ground_resistor_o   <= next_cfg[CFG_GND_RES]; // R3
        end
    end
endmodule

/* File: verification/arm_adc_model.sv */
module arm_adc_model (
    input  wire logic        clk_i,    // System clock.
    input  wire logic        req_i,    // Issue one result.
    input  wire logic [23:0] value_i,  // Result to issue.
    output logic      [23:0] result_o, // Filter output word.
    output logic             strobe_o  // One-cycle result strobe.
);
    timeunit 1ns;
    timeprecision 1ns;
    initial strobe_o = 1'b0;
    initial result_o = 24'h00_0000;
    // Between strobes the word flips so that a stale capture cannot pass.
    always @(posedge clk_i) begin
        strobe_o <= req_i;
        result_o <= req_i ? value_i : ~result_o;
    end
endmodule

/* File: verification/arm_chk.sv */
module arm_chk import arm_pkg::*; (
    input wire logic        clk_i, rst_n_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i,
    input wire logic        s_axi_wready_o, s_axi_bvalid_o, s_axi_arvalid_i, s_axi_arready_o,
    input wire logic        s_axi_rvalid_o, s_axi_rready_i, ground_switch_pin_o, ground_resistor_o, irq_o,
    input wire logic [31:0] s_axi_awaddr_i, s_axi_rdata_o,
    input wire logic [1:0]  s_axi_bresp_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
        |=> ##1 s_axi_bvalid_o) else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read response late");
    a_read_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data not held");
    a_reset_quiet: assert property ($rose(rst_n_i) |-> !irq_o && !ground_switch_pin_o && !ground_resistor_o)
        else $error("outputs not quiet after reset");
    a_switch_by_write: assert property ($changed(ground_switch_pin_o) |-> s_axi_bvalid_o || $past(s_axi_bvalid_o)
        || $past(s_axi_bvalid_o, 2)) else $error("switch moved without write");
    a_resistor_by_write: assert property ($changed(ground_resistor_o) |-> s_axi_bvalid_o || $past(s_axi_bvalid_o)
        || $past(s_axi_bvalid_o, 2)) else $error("resistor moved without write");
    a_config_okay: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_awaddr_i == ADDR_CFG
        |-> ##[1:8] s_axi_bvalid_o && s_axi_bresp_o == RESP_OKAY) else $error("config write refused");
    a_unmapped_err: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_awaddr_i == 32'hFFFF_0000
        |-> ##[1:8] s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR) else $error("unmapped write accepted");
endmodule
bind arm_top arm_chk u_arm_chk (.*);

/* File: verification/tb_arm_top.sv */
module tb_arm_top;
    timeunit 1ns;
    timeprecision 1ns;
    import arm_pkg::*;
    logic        clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, mdl_req = 1'b0, coarse_overrange_i = 1'b0;
    logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, result_valid_i;
    logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic        ground_switch_pin_o, ground_resistor_o, irq_o;
    logic [31:0] s_axi_awaddr_i = '0, s_axi_wdata_i = '0, s_axi_araddr_i = '0, s_axi_rdata_o, d;
    logic [3:0]  s_axi_wstrb_i = 4'hF;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, r;
    logic [23:0] result_i, mdl_val = '0;
    int          error_cnt = 0, comparisons = 0, cyc = 0;
    localparam logic [31:0] RA [6] = '{ADDR_CFG, ADDR_MSK, ADDR_TH, ADDR_RCR, 32'hFFFF_0000, ADDR_THV};
    localparam logic [31:0] RD [6] = '{32'h182, 32'h20, 32'h64, 32'h3, 32'h5, 32'h5};
    localparam logic [31:0] RE [6] = '{32'h82, 32'h20, 32'h64, 32'h3, 32'h0, 32'h0};
    localparam logic [1:0]  RB [6] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_SLVERR, RESP_SLVERR};
    localparam logic [1:0]  RR [6] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_SLVERR, RESP_OKAY};
    localparam logic [23:0] SEQ [5] = '{24'h64, 24'h64, 24'h32, 24'h64, 24'h64};

    arm_top u_arm_top (.*);
    arm_adc_model u_arm_adc_model (.clk_i(clk_i), .req_i(mdl_req), .value_i(mdl_val), .result_o(result_i),
                                   .strobe_o(result_valid_i));

    initial forever #20 clk_i = ~clk_i;

    task automatic finish_test();
        $display("TB: %0d comparisons, %0d errors", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge clk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= v;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        repeat (40) begin
            @(posedge clk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
            if (s_axi_bvalid_o) break;
        end
        rs = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    // Ready is raised only after the answer shows, so the slave must hold it.
    task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge clk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        repeat (40) begin
            @(posedge clk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
            if (s_axi_rvalid_o && s_axi_rready_i) break;
            if (s_axi_rvalid_o) s_axi_rready_i <= 1'b1;
        end
        v = s_axi_rdata_o;
        rs = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] v;
        logic [1:0]  rs;
        rd(a, v, rs);
        chk(v, exp);
    endtask

    task automatic pulse(input logic [23:0] v);
        @(posedge clk_i);
        mdl_req <= 1'b1;
        mdl_val <= v;
        @(posedge clk_i);
        mdl_req <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    // Reading the result after each strobe keeps the result register live.
    task automatic conv(input logic [23:0] v);
        pulse(v);
        rd(ADDR_DAT, d, r);
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end

    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rchk(ADDR_CFG, 32'h0);
        chk(32'({ground_switch_pin_o, ground_resistor_o, irq_o}), 32'h0);
        for (int i = 0; i < 6; i++) begin
            wr(RA[i], RD[i], r);
            chk(32'(r), 32'(RB[i]));
            rd(RA[i], d, r);
            chk(d, RE[i]);
            chk(32'(r), 32'(RR[i]));
        end
        chk(32'({ground_switch_pin_o, ground_resistor_o}), 32'h3);
        wr(ADDR_CFG, 32'h80, r);
        chk(32'({ground_switch_pin_o, ground_resistor_o}), 32'h2);
        wr(ADDR_CFG, 32'h0, r);
        chk(32'(ground_switch_pin_o), 32'h0);
        $display("TB: test config done");
        pulse(24'h7);
        chk(32'(irq_o), 32'h1);
        pulse(24'h9);
        rchk(ADDR_DAT, 32'h7);
        rchk(ADDR_STA, 32'h20);
        wr(ADDR_STA, 32'h20, r);
        chk(32'(irq_o), 32'h0);
        wr(ADDR_MSK, 32'h0, r);
        conv(24'h1);
        chk(32'(irq_o), 32'h0);
        wr(ADDR_MSK, 32'h20, r);
        chk(32'(irq_o), 32'h1);
        wr(ADDR_STA, 32'hFF, r);
        wr(ADDR_CFG, 32'h1, r);
        conv(24'h1);
        conv(24'h1);
        rchk(ADDR_STA, 32'h0);
        conv(24'h1);
        rchk(ADDR_STA, 32'h20);
        $display("TB: test interrupt done");
        wr(ADDR_CFG, 32'h20, r);
        conv(24'h5);
        conv(24'hFF_FFF6);
        rchk(ADDR_ACC, 32'h0);
        conv(24'h3);
        rchk(ADDR_ACC, 32'h3);
        wr(ADDR_CFG, 32'h0, r);
        conv(24'h0);
        conv(24'h0);
        wr(ADDR_CFG, 32'h40, r);
        conv(24'h5);
        conv(24'hFF_FFF6);
        rchk(ADDR_ACC, 32'hFFFF_FFFB);
        wr(ADDR_MSK, 32'h40, r);
        wr(ADDR_CFG, 32'h60, r);
        wr(ADDR_STA, 32'hFF, r);
        conv(24'h64);
        chk(32'(irq_o), 32'h0);
        conv(24'h5);
        chk(32'(irq_o), 32'h1);
        $display("TB: test accumulator done");
        wr(ADDR_CFG, 32'h8, r);
        wr(ADDR_STA, 32'hFF, r);
        conv(24'h63);
        rchk(ADDR_STA, 32'h20);
        conv(24'hFF_FF9C);
        rchk(ADDR_STA, 32'h28);
        wr(ADDR_THC, 32'h3, r);
        for (int m = 0; m < 2; m++) begin
            wr(ADDR_CFG, 32'h0, r);
            wr(ADDR_STA, 32'hFF, r);
            wr(ADDR_CFG, m ? 32'h18 : 32'h10, r);
            for (int k = 0; k < 5; k++) conv(SEQ[k]);
            rchk(ADDR_STA, m ? 32'h28 : 32'h20);
        end
        $display("TB: test comparator done");
        wr(ADDR_CFG, 32'h4, r);
        wr(ADDR_STA, 32'hFF, r);
        coarse_overrange_i <= 1'b1;
        repeat (3000) @(posedge clk_i);
        coarse_overrange_i <= 1'b0;
        rchk(ADDR_STA, 32'h0);
        coarse_overrange_i <= 1'b1;
        repeat (3200) @(posedge clk_i);
        rchk(ADDR_STA, 32'h4);
        $display("TB: test overrange done");
        finish_test();
    end
endmodule
